// *** verification/mebc_chk.sv ***
// port assertions for the acquisition control
`default_nettype none
module mebc_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic gate_pin,
    input wire logic front_reset_pin,
    input wire logic conv_start,
    input wire logic busy_out,
    input wire logic busy_oe,
    input wire logic busy_led,
    input wire logic data_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [2:0] age_r;
    // cycles since host or front reset activity, saturating
    always_ff @(posedge sys_clk) begin
        if (rst || rd || wr || front_reset_pin) begin
            age_r <= 3'h0;
        end else if (age_r != 3'h7) begin
            age_r <= age_r + 3'h1;
        end
    end
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    chk_busy_conv: assert property (conv_start |-> busy_out && busy_led)
        else $error("no busy with conversion start");
    chk_busy_pins: assert property (busy_oe == busy_out && busy_led == busy_out)
        else $error("busy outputs disagree");
    chk_start_idle: assert property (conv_start |-> !$past(busy_out))
        else $error("gate accepted while busy");
    chk_start_gate: assert property (conv_start |->
        $past(gate_pin, 2) || $past(gate_pin, 3) || $past(gate_pin, 4))
        else $error("conversion start without gate");
    chk_window_empty: assert property (rd && addr <= 16'h07FC && !data_ready
        |=> rdata == 32'h0600_0000)
        else $error("empty window read not invalid word");
    chk_ready_hold: assert property (data_ready && age_r == 3'h7
        |=> data_ready)
        else $error("buffer emptied without host action");
endmodule
bind mebc_top mebc_chk chk_u (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wr(wr), .rd(rd), .rdata(rdata), .gate_pin(gate_pin),
    .front_reset_pin(front_reset_pin), .conv_start(conv_start),
    .busy_out(busy_out), .busy_oe(busy_oe), .busy_led(busy_led),
    .data_ready(data_ready));
`default_nettype wire

// *** verification/mebc_fe_model.sv ***
// front-end digitiser model answering each conversion start
`default_nettype none
module mebc_fe_model (
    input wire logic sys_clk,
    input wire logic conv_start,
    input wire logic analog_clear,
    input wire logic [5:0] nch,
    input wire logic [31:0] keep_mask,
    input wire logic [7:0] lat,
    output mebc_pkg::mebc_chan_type chan,
    output logic conv_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int step = -1;
    initial begin
        chan = '0;
        conv_done = 1'b0;
    end
    // one result a cycle after the latency; a clear drops the sequence
    always @(posedge sys_clk) begin
        conv_done <= 1'b0;
        chan.valid <= 1'b0;
        chan.keep <= 1'b0;
        chan.word <= ~chan.word; // idle data keeps moving, never stale
        if (analog_clear) begin
            step <= -1;
        end else if (conv_start) begin
            step <= 0;
        end else if (step >= 0) begin
            step <= step + 1;
            if (step >= lat && step < lat + nch) begin
                chan.valid <= 1'b1;
                chan.keep <= keep_mask[step - lat];
                chan.word <= {16'hA05A, 8'h00, 8'(step - lat)};
            end
            // gap cycle keeps the done pulse off the last result
            if (step == lat + nch + 1) begin
                conv_done <= 1'b1;
                step <= -1;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/mebc_top_tb.sv ***
// self-checking bench for the acquisition control
`default_nettype none
module mebc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata, keep_mask = 32'h0;
    logic gate_pin = 1'b0, gate_inhibit_pin = 1'b0, abort_pulse_pin = 1'b0;
    logic front_reset_pin = 1'b0, other_busy = 1'b0, halt_on_any_busy = 1'b0;
    logic shared_busy_in, conv_done, conv_start, analog_clear, data_ready;
    logic busy_out, busy_oe, busy_led;
    logic [5:0] nch = 6'h0;
    logic [7:0] lat = 8'h2;
    logic [23:0] cnt_exp = 24'h0;
    mebc_pkg::mebc_chan_type chan;
    logic [63:0] exp_q[$];
    int seed = 25454;
    int num_errors = 0, checked = 0, starts = 0, cycles = 0;
    localparam logic [31:0] STM = 32'h0000_0013; // ready, full, empty
    always #10 sys_clk = ~sys_clk;
    // wired-or busy line: our driver plus the other modules
    assign shared_busy_in = other_busy | busy_oe;
    mebc_top dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .gate_pin(gate_pin),
        .gate_inhibit_pin(gate_inhibit_pin), .abort_pulse_pin(abort_pulse_pin),
        .front_reset_pin(front_reset_pin), .shared_busy_in(shared_busy_in),
        .halt_on_any_busy(halt_on_any_busy), .chan(chan),
        .conv_done(conv_done), .conv_start(conv_start),
        .analog_clear(analog_clear), .busy_out(busy_out), .busy_oe(busy_oe),
        .busy_led(busy_led), .data_ready(data_ready));
    mebc_fe_model fe_u (.sys_clk(sys_clk), .conv_start(conv_start),
        .analog_clear(analog_clear), .nch(nch), .keep_mask(keep_mask),
        .lat(lat), .chan(chan), .conv_done(conv_done));
    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] ex);
        checked++;
        if (seen !== ex) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // answer monitor and hang limit
    always @(posedge sys_clk) begin
        cycles++;
        if (conv_start === 1'b1)
            starts++;
        if (rd_d) begin
            chk("rdata", rdata & exp_q[0][63:32], exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
        rd_d <= rd;
        if (cycles > 20000) begin
            num_errors++;
            end_sim();
        end
    end
    function automatic logic [15:0] win();
        return 16'($random(seed)) & 16'h07FC;
    endfunction
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd_reg(input logic [15:0] a, input logic [31:0] m,
            input logic [31:0] ex);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        exp_q.push_back({m, ex});
        @(posedge sys_clk);
    endtask
    // one gate pulse, held past the input synchroniser
    task automatic gate();
        gate_pin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        gate_pin <= 1'b0;
        cnt_exp++;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic run(input logic [5:0] n, input logic [31:0] km);
        idle(1);
        nch <= n;
        keep_mask <= km;
        gate();
        // a full buffer keeps busy up, so the wait is bounded
        for (int i = 0; i < 300 && busy_out !== 1'b0; i++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic read_event(input int n, input logic [31:0] km,
            input logic [23:0] tr);
        logic [5:0] k;
        k = 6'h0;
        for (int i = 0; i < n; i++)
            k = k + 6'(km[i]);
        rd_reg(win(), 32'h0700_3F00, {8'h02, 10'h0, k, 8'h0});
        for (int i = 0; i < n; i++)
            if (km[i])
                rd_reg(win(), 32'h07FF_FFFF, {16'h005A, 8'h0, 8'(i)});
        rd_reg(win(), 32'h07FF_FFFF, {8'h04, tr});
        idle(3);
    endtask
    task automatic front_rst();
        front_reset_pin <= 1'b1;
        repeat (2) @(posedge sys_clk);
        front_reset_pin <= 1'b0;
        idle(6);
    endtask
    task automatic abort_at(input logic [7:0] d, input logic hit);
        int c0;
        c0 = starts;
        lat <= 8'd30;
        nch <= 6'd1;
        keep_mask <= 32'h1;
        gate();
        repeat (d) @(posedge sys_clk);
        abort_pulse_pin <= 1'b1;
        repeat (2) @(posedge sys_clk);
        abort_pulse_pin <= 1'b0;
        gate();
        chk("clear", 32'(analog_clear), 32'(hit));
        chk("early gate", 32'(starts - c0), 32'h1);
        repeat (40) @(posedge sys_clk);
        lat <= 8'd2;
        if (hit)
            rd_reg(mebc_pkg::REG_STATUS, STM, 32'h10);
        else
            read_event(1, 32'h1, cnt_exp);
        idle(1);
    endtask
    initial begin
        logic [31:0] km;
        int c0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd_reg(mebc_pkg::REG_MODE, 32'hFFFF, 32'h4000);
        rd_reg(mebc_pkg::REG_STATUS, STM, 32'h10);
        rd_reg(win(), '1, 32'h0600_0000);
        rd_reg(16'h0F00, '1, 32'h0);
        idle(1);
        $display("reset test done");
        // auto advance: random pick, widest event, nothing kept
        wr_reg(mebc_pkg::REG_MODE, 32'h4800);
        km = $random(seed) | 32'h1;
        run(6'd9, km);
        rd_reg(mebc_pkg::REG_STATUS, STM, 32'h1);
        read_event(9, km, cnt_exp);
        run(6'd32, '1);
        read_event(32, '1, cnt_exp);
        run(6'd3, 32'h0);
        rd_reg(mebc_pkg::REG_STATUS, STM, 32'h10);
        wr_reg(mebc_pkg::REG_MODE, 32'h5800);
        run(6'd3, 32'h0);
        read_event(0, 32'h0, cnt_exp);
        rd_reg(mebc_pkg::REG_STATUS, STM, 32'h10);
        idle(1);
        $display("event test done");
        // pointer moved only by the two step registers
        wr_reg(mebc_pkg::REG_MODE, 32'h4000);
        run(6'd2, 32'h3);
        rd_reg(win(), 32'h0700_0000, 32'h0200_0000);
        rd_reg(win(), 32'h0700_0000, 32'h0200_0000);
        wr_reg(mebc_pkg::REG_NEXT_WORD, 32'h0);
        idle(1);
        rd_reg(win(), 32'h07FF_FFFF, 32'h005A_0000);
        wr_reg(mebc_pkg::REG_NEXT_EVT, 32'h0);
        idle(3);
        rd_reg(mebc_pkg::REG_STATUS, STM, 32'h10);
        $display("pointer test done");
        // only accepted gates counted
        wr_reg(mebc_pkg::REG_MODE, 32'h0800);
        gate_inhibit_pin <= 1'b1;
        c0 = starts;
        run(6'd1, 32'h1);
        cnt_exp--;
        chk("vetoed gate", 32'(starts - c0), 32'h0);
        gate_inhibit_pin <= 1'b0;
        run(6'd1, 32'h1);
        read_event(1, 32'h1, cnt_exp);
        rd_reg(mebc_pkg::REG_CNT_LO, 32'hFFFF, 32'(cnt_exp[15:0]));
        rd_reg(mebc_pkg::REG_CNT_HI, 32'hFF, 32'(cnt_exp[23:16]));
        wr_reg(mebc_pkg::REG_MODE, 32'h4800);
        idle(1);
        abort_at(8'd2, 1'b1);
        run(6'd1, 32'h1);
        read_event(1, 32'h1, cnt_exp);
        abort_at(8'd20, 1'b0);
        $display("abort test done");
        // shared busy line shown; strap decides halting
        other_busy <= 1'b1;
        idle(3);
        rd_reg(mebc_pkg::REG_STATUS, 32'h8, 32'h8);
        c0 = starts;
        run(6'd1, 32'h1);
        halt_on_any_busy <= 1'b1;
        run(6'd1, 32'h1);
        chk("halt", 32'(starts - c0), 32'h1);
        other_busy <= 1'b0;
        halt_on_any_busy <= 1'b0;
        read_event(1, 32'h1, cnt_exp - 24'h1);
        $display("busy test done");
        // fill every slot, refuse a gate, free one slot
        c0 = starts;
        repeat (33) run(6'd1, 32'h1);
        chk("full starts", 32'(starts - c0), 32'd32);
        chk("full busy", 32'(busy_out), 32'h1);
        rd_reg(mebc_pkg::REG_STATUS, 32'h1F, 32'h0F);
        read_event(1, 32'h1, cnt_exp - 24'd32);
        rd_reg(mebc_pkg::REG_STATUS, 32'h1F, 32'h01);
        // data reset by held bit, by front pulse; soft resets
        wr_reg(mebc_pkg::REG_BITSET, 32'h4);
        idle(3);
        rd_reg(mebc_pkg::REG_STATUS, STM, 32'h10);
        rd_reg(mebc_pkg::REG_CNT_LO, 32'hFFFF, 32'h0);
        wr_reg(mebc_pkg::REG_BITCLR, 32'h4);
        cnt_exp = 24'h0;
        run(6'd1, 32'h1);
        front_rst();
        rd_reg(mebc_pkg::REG_STATUS, STM, 32'h10);
        wr_reg(mebc_pkg::REG_MODE, 32'h0);
        wr_reg(mebc_pkg::REG_SHOT, 32'h0);
        idle(2);
        rd_reg(mebc_pkg::REG_MODE, 32'hFFFF, 32'h4000);
        wr_reg(mebc_pkg::REG_CTRL, 32'h10);
        wr_reg(mebc_pkg::REG_MODE, 32'h0);
        idle(1);
        front_rst();
        rd_reg(mebc_pkg::REG_MODE, 32'hFFFF, 32'h4000);
        idle(3);
        $display("reset kinds test done");
        chk("notes left", 32'(exp_q.size()), 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire

// *** verilog/mebc_pkg.sv ***
// constants and types shared by the multi-event buffer acquisition control
`default_nettype none
package mebc_pkg;
    // storage geometry
    localparam int EVT_SLOTS = 32;
    localparam int WORDS_PER_EVT = 34;
    localparam int MEM_DEPTH = EVT_SLOTS * WORDS_PER_EVT;
    localparam int EVT_W = 5;
    localparam int WORD_W = 6;
    localparam int IDX_W = 11;
    localparam int CNT_W = 24;
    localparam int ADDR_W = 16;
    localparam logic [5:0] MAX_DATA_WORDS = 6'h20;
    localparam logic [5:0] LAST_WORD = 6'h21;
    // register map (byte addresses)
    localparam logic [15:0] WIN_LAST = 16'h07FC;
    localparam logic [15:0] REG_STATUS = 16'h0800;
    localparam logic [15:0] REG_CTRL = 16'h0804;
    localparam logic [15:0] REG_BITSET = 16'h0808;
    localparam logic [15:0] REG_BITCLR = 16'h080C;
    localparam logic [15:0] REG_MODE = 16'h0810;
    localparam logic [15:0] REG_SHOT = 16'h0814;
    localparam logic [15:0] REG_NEXT_EVT = 16'h0818;
    localparam logic [15:0] REG_NEXT_WORD = 16'h081C;
    localparam logic [15:0] REG_CNT_LO = 16'h0820;
    localparam logic [15:0] REG_CNT_HI = 16'h0824;
    localparam logic [15:0] REG_FCW = 16'h0828;
    // field positions
    localparam int CTL_MEM_TEST_BIT = 0;
    localparam int CTL_FRONT_SCOPE_BIT = 4;
    localparam int SET_CLEAR_DATA_BIT = 2;
    localparam int SET_SOFT_RESET_BIT = 7;
    localparam int MODE_AUTO_BIT = 11;
    localparam int MODE_EMPTY_EN_BIT = 12;
    localparam int MODE_COUNT_EVERY_BIT = 14;
    localparam int ST_READY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_GBUSY_BIT = 3;
    localparam int ST_EMPTY_BIT = 4;
    localparam int TAG_LSB = 24;
    localparam int HDR_CNT_LSB = 8;
    // reset values
    localparam logic [15:0] MODE_RESET = 16'h4000;
    localparam logic [7:0] FCW_RESET = 8'h0F;
    // word tags
    localparam logic [2:0] TAG_DATA = 3'h0;
    localparam logic [2:0] TAG_HEADER = 3'h2;
    localparam logic [2:0] TAG_TRAILER = 3'h4;
    localparam logic [2:0] TAG_INVALID = 3'h6;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int ABORT_RECOVER_NS = 600;
    localparam int ABORT_RECOVER_CYC =
        (ABORT_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] RECOVER_LAST = 6'(ABORT_RECOVER_CYC - 1);

    typedef struct packed {
        logic [4:0] evt;
        logic [5:0] word;
    } mebc_ptr_type;

    typedef struct packed {
        logic valid;
        logic keep;
        logic [31:0] word;
    } mebc_chan_type;

    typedef enum {
        ST_IDLE,
        ST_CONV,
        ST_TRAIL,
        ST_HEAD,
        ST_RECOVER
    } mebc_state_type;
endpackage
`default_nettype wire

// *** verilog/mebc_top.sv ***
// multi-event buffer, event counter, busy, reset and fast-clear control
//
// The strobed register port and the placing of the registers were left to the implementer.
`default_nettype none
module mebc_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic gate_pin,
    input wire logic gate_inhibit_pin,
    input wire logic abort_pulse_pin,
    input wire logic front_reset_pin,
    input wire logic shared_busy_in,
    input wire logic halt_on_any_busy,
    input wire mebc_pkg::mebc_chan_type chan,
    input wire logic conv_done,
    output logic conv_start,
    output logic analog_clear,
    output logic busy_out,
    output logic busy_oe,
    output logic busy_led,
    output logic data_ready
);
    localparam int NPIN = 6;

    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [NPIN-1:0] seen_r;
    logic gate_rise, abort_rise, front_rise;
    logic inhibit_lvl, abort_lvl, shared_busy, halt_any;
    logic [15:0] ctrl_r;
    logic clear_bit_r, soft_bit_r;
    logic [15:0] mode_r;
    logic [7:0] fcw_r;
    logic shot, soft_rst, data_rst;
    logic auto_adv, empty_en, count_every;
    mebc_pkg::mebc_state_type state_r;
    mebc_pkg::mebc_ptr_type wp_r, rp_r;
    logic [5:0] nwords_r;
    logic [7:0] win_cnt_r;
    logic [5:0] rec_cnt_r;
    logic [23:0] evt_cnt_r;
    logic last_write_r;
    logic [31:0] mem [mebc_pkg::MEM_DEPTH];
    logic mem_we;
    logic [10:0] mem_widx;
    logic [31:0] mem_wdata;
    logic [10:0] ridx;
    logic [31:0] cur_word;
    logic same_evt, empty, full, own_busy, halt, gate_ok;
    logic rd_win, rp_evt_adv, rp_word_adv, wp_adv, accept_word;
    logic [31:0] rdata_r;
    logic busy_r, conv_start_r, analog_clear_r, ready_r;

    function automatic logic [10:0] mem_idx(
        input mebc_pkg::mebc_ptr_type p
    );
        return 11'(p.evt * mebc_pkg::WORDS_PER_EVT) + 11'(p.word);
    endfunction

    // pins cross into the clock domain through two flops each
    assign pin_in = {halt_on_any_busy, shared_busy_in, front_reset_pin,
                     abort_pulse_pin, gate_inhibit_pin, gate_pin};
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            seen_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            seen_r <= sync2_r;
        end
    end
    assign gate_rise = sync2_r[0] & ~seen_r[0];
    assign inhibit_lvl = sync2_r[1];
    assign abort_lvl = sync2_r[2];
    assign abort_rise = sync2_r[2] & ~seen_r[2];
    assign front_rise = sync2_r[3] & ~seen_r[3];
    assign shared_busy = sync2_r[4];
    assign halt_any = sync2_r[5];

    // reset classes nest: hardware inside software inside data
    assign shot = wr && (addr == mebc_pkg::REG_SHOT);
    assign soft_rst = rst | soft_bit_r | shot
        | (front_rise & ctrl_r[mebc_pkg::CTL_FRONT_SCOPE_BIT]);
    assign data_rst = soft_rst | clear_bit_r
        | (front_rise & ~ctrl_r[mebc_pkg::CTL_FRONT_SCOPE_BIT]);

    // control register survives everything but hardware reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= '0;
        end else if (wr && addr == mebc_pkg::REG_CTRL) begin
            ctrl_r <= wdata[15:0];
        end
    end

    // persistent reset bits, set and cleared by separate writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clear_bit_r <= 1'b0;
            soft_bit_r <= 1'b0;
        end else if (wr && addr == mebc_pkg::REG_BITSET) begin
            if (wdata[mebc_pkg::SET_CLEAR_DATA_BIT])
                clear_bit_r <= 1'b1;
            if (wdata[mebc_pkg::SET_SOFT_RESET_BIT])
                soft_bit_r <= 1'b1;
        end else if (wr && addr == mebc_pkg::REG_BITCLR) begin
            if (wdata[mebc_pkg::SET_CLEAR_DATA_BIT])
                clear_bit_r <= 1'b0;
            if (wdata[mebc_pkg::SET_SOFT_RESET_BIT])
                soft_bit_r <= 1'b0;
        end
    end

    // mode and window registers form the software-reset subset
    always_ff @(posedge sys_clk) begin
        if (soft_rst) begin
            mode_r <= mebc_pkg::MODE_RESET;
            fcw_r <= mebc_pkg::FCW_RESET;
        end else if (wr && addr == mebc_pkg::REG_MODE) begin
            mode_r <= wdata[15:0];
        end else if (wr && addr == mebc_pkg::REG_FCW) begin
            fcw_r <= wdata[7:0];
        end
    end
    assign auto_adv = mode_r[mebc_pkg::MODE_AUTO_BIT];
    assign empty_en = mode_r[mebc_pkg::MODE_EMPTY_EN_BIT];
    assign count_every = mode_r[mebc_pkg::MODE_COUNT_EVERY_BIT];

    // buffer status from pointers and the last advance
    assign same_evt = (rp_r.evt == wp_r.evt);
    assign empty = same_evt & ~last_write_r;
    assign full = same_evt & last_write_r;
    // own busy; the synced shared line lags, so own busy is ORed in
    assign own_busy = (state_r != mebc_pkg::ST_IDLE) | data_rst
        | full | ctrl_r[mebc_pkg::CTL_MEM_TEST_BIT];
    assign halt = halt_any ? (shared_busy | own_busy) : own_busy;
    assign gate_ok = gate_rise & ~inhibit_lvl & ~abort_lvl
        & ~halt;

    // gate counter; every edge counts unless accepted-only mode
    always_ff @(posedge sys_clk) begin
        if (data_rst) begin
            evt_cnt_r <= '0;
        end else if (gate_rise && (count_every || gate_ok)) begin
            evt_cnt_r <= evt_cnt_r + 24'h00_0001;
        end
    end

    assign accept_word = chan.valid & chan.keep
        & (nwords_r < mebc_pkg::MAX_DATA_WORDS);
    assign wp_adv = (state_r == mebc_pkg::ST_HEAD);

    // conversion sequencer; an abort inside the fast-clear window discards the slot being built
    always_ff @(posedge sys_clk) begin
        if (data_rst) begin
            state_r <= mebc_pkg::ST_IDLE;
            wp_r <= '0;
            nwords_r <= '0;
            win_cnt_r <= '0;
            rec_cnt_r <= '0;
        end else begin
            case (state_r)
                mebc_pkg::ST_IDLE: begin
                    nwords_r <= '0;
                    win_cnt_r <= '0;
                    if (gate_ok)
                        state_r <= mebc_pkg::ST_CONV;
                end
                mebc_pkg::ST_CONV: begin
                    if (win_cnt_r != 8'hFF)
                        win_cnt_r <= win_cnt_r + 8'h01;
                    if (abort_rise && win_cnt_r < fcw_r) begin
                        state_r <= mebc_pkg::ST_RECOVER;
                        rec_cnt_r <= '0;
                    end else if (conv_done) begin
                        if (nwords_r != 6'h00 || empty_en)
                            state_r <= mebc_pkg::ST_TRAIL;
                        else
                            state_r <= mebc_pkg::ST_IDLE;
                    end else if (accept_word) begin
                        nwords_r <= nwords_r + 6'h01;
                    end
                end
                mebc_pkg::ST_TRAIL: begin
                    state_r <= mebc_pkg::ST_HEAD;
                end
                mebc_pkg::ST_HEAD: begin
                    wp_r.evt <= wp_r.evt + 5'h01;
                    wp_r.word <= '0;
                    state_r <= mebc_pkg::ST_IDLE;
                end
                mebc_pkg::ST_RECOVER: begin
                    // hold off gates through the clear-conversion cycle
                    if (rec_cnt_r == mebc_pkg::RECOVER_LAST)
                        state_r <= mebc_pkg::ST_IDLE;
                    else
                        rec_cnt_r <= rec_cnt_r + 6'h01;
                end
                default: begin
                    state_r <= mebc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // one write port; data words first, trailer, header last
    always_comb begin
        mem_we = 1'b0;
        mem_widx = '0;
        mem_wdata = '0;
        case (state_r)
            mebc_pkg::ST_CONV: begin
                mem_we = accept_word & ~conv_done & ~abort_rise;
                mem_widx = mem_idx('{evt: wp_r.evt,
                                     word: nwords_r + 6'h01});
                mem_wdata = {5'h00, mebc_pkg::TAG_DATA, chan.word[23:0]};
            end
            mebc_pkg::ST_TRAIL: begin
                mem_we = 1'b1;
                mem_widx = mem_idx('{evt: wp_r.evt,
                                     word: nwords_r + 6'h01});
                mem_wdata = {5'h00, mebc_pkg::TAG_TRAILER,
                             evt_cnt_r};
            end
            mebc_pkg::ST_HEAD: begin
                mem_we = 1'b1;
                mem_widx = mem_idx('{evt: wp_r.evt, word: 6'h00});
                mem_wdata = {5'h00, mebc_pkg::TAG_HEADER, 10'h000,
                             nwords_r, 8'h00};
            end
            default: begin
                mem_we = 1'b0;
            end
        endcase
    end

    // event storage; a data reset wipes every slot
    always_ff @(posedge sys_clk) begin
        if (data_rst) begin
            for (int i = 0; i < mebc_pkg::MEM_DEPTH; i++)
                mem[i] <= '0;
        end else if (mem_we) begin
            mem[mem_widx] <= mem_wdata;
        end
    end

    // read pointer moves, unless the buffer is empty, by register write or, in auto-advance mode, after each window read
    assign ridx = mem_idx(rp_r);
    assign cur_word = mem[ridx];
    assign rd_win = rd && (addr <= mebc_pkg::WIN_LAST);
    assign rp_evt_adv = ~empty & ((wr && addr == mebc_pkg::REG_NEXT_EVT)
        | (auto_adv & rd_win
           & (cur_word[26:24] == mebc_pkg::TAG_TRAILER)));
    assign rp_word_adv = ~empty & ((wr && addr == mebc_pkg::REG_NEXT_WORD)
        | (auto_adv & rd_win
           & (cur_word[26:24] != mebc_pkg::TAG_TRAILER)));
    always_ff @(posedge sys_clk) begin
        if (data_rst) begin
            rp_r <= '0;
        end else if (rp_evt_adv) begin
            rp_r.evt <= rp_r.evt + 5'h01;
            rp_r.word <= '0;
        end else if (rp_word_adv && rp_r.word != mebc_pkg::LAST_WORD) begin
            rp_r.word <= rp_r.word + 6'h01;
        end
    end

    // a write advance wins over a read advance in the same cycle
    always_ff @(posedge sys_clk) begin
        if (data_rst) begin
            last_write_r <= 1'b0;
        end else if (wp_adv) begin
            last_write_r <= 1'b1;
        end else if (rp_evt_adv) begin
            last_write_r <= 1'b0;
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (!rd) begin
            rdata_r <= '0;
        end else if (addr <= mebc_pkg::WIN_LAST) begin
            if (empty)
                rdata_r <= {5'h00, mebc_pkg::TAG_INVALID, 24'h00_0000};
            else
                rdata_r <= cur_word;
        end else begin
            case (addr)
                mebc_pkg::REG_STATUS: begin
                    rdata_r <= '0;
                    rdata_r[mebc_pkg::ST_READY_BIT] <= ~empty;
                    rdata_r[mebc_pkg::ST_FULL_BIT] <= full;
                    rdata_r[mebc_pkg::ST_BUSY_BIT] <= busy_r;
                    rdata_r[mebc_pkg::ST_GBUSY_BIT] <= shared_busy;
                    rdata_r[mebc_pkg::ST_EMPTY_BIT] <= empty;
                end
                mebc_pkg::REG_CTRL: rdata_r <= {16'h0000, ctrl_r};
                mebc_pkg::REG_BITSET,
                mebc_pkg::REG_BITCLR: begin
                    rdata_r <= '0;
                    rdata_r[mebc_pkg::SET_CLEAR_DATA_BIT] <= clear_bit_r;
                    rdata_r[mebc_pkg::SET_SOFT_RESET_BIT] <= soft_bit_r;
                end
                mebc_pkg::REG_MODE: rdata_r <= {16'h0000, mode_r};
                mebc_pkg::REG_FCW: rdata_r <= {24'h00_0000, fcw_r};
                mebc_pkg::REG_CNT_LO:
                    rdata_r <= {16'h0000, evt_cnt_r[15:0]};
                mebc_pkg::REG_CNT_HI:
                    rdata_r <= {24'h00_0000, evt_cnt_r[23:16]};
                default: rdata_r <= '0;
            endcase
        end
    end

    // registered outputs toward the front end and the panel
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_r <= 1'b1;
            conv_start_r <= 1'b0;
            analog_clear_r <= 1'b1;
            ready_r <= 1'b0;
        end else begin
            busy_r <= own_busy | gate_ok;
            conv_start_r <= gate_ok;
            analog_clear_r <= data_rst
                | (state_r == mebc_pkg::ST_RECOVER);
            ready_r <= ~empty;
        end
    end

    assign rdata = rdata_r;
    assign conv_start = conv_start_r;
    assign analog_clear = analog_clear_r;
    assign busy_out = busy_r;
    assign busy_oe = busy_r;
    assign busy_led = busy_r;
    assign data_ready = ready_r;
endmodule
`default_nettype wire
